// >>> src/diag_image.sv
// diagnostic image for an eight port i/o master, ahb-lite register slave
// assumes pin level inputs are asynchronous, one clock domain
`timescale 1ns/1ns

module diag_image #(
  parameter int unsigned NCH   = 16,
  parameter int unsigned NPORT = 8,
  parameter int unsigned FILT  = diag_image_pkg::FILT_CYC,
  parameter int unsigned MSCYC = diag_image_pkg::CYC_PER_MS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] out_cmd_i,
  input  wire logic [15:0] out_meas_i,
  input  wire logic [7:0]  gen_cond_i,
  input  wire logic [7:0]  port_comm_fault_i,
  input  wire logic [7:0]  port_valid_mismatch_i,
  input  wire logic [15:0] port_diag_class_i,
  input  wire logic [15:0] sel_vendor_id_i,
  input  wire logic [15:0] sel_device_id_i,
  input  wire logic [15:0] sel_event_code_i,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [2:0]  port_sel_o
);
  import diag_image_pkg::*;

  // ****************************************************
  // input synchronisers
  // ****************************************************
  localparam int unsigned SW = 16 + 8 + 8 + 8 + 16;
  logic [SW-1:0] s1_q, s2_q;
  logic [15:0]   meas_s;
  logic [7:0]    gen_s, comm_s, vmis_s;
  logic [15:0]   cls_s;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (ce_i) begin
      s1_q <= {out_meas_i, gen_cond_i, port_comm_fault_i,
               port_valid_mismatch_i, port_diag_class_i};
      s2_q <= s1_q;
    end
  end
  assign {meas_s, gen_s, comm_s, vmis_s, cls_s} = s2_q;

  // ****************************************************
  // configuration registers and bus slave
  // ****************************************************
  logic [7:0]  surv_q, surv_d;
  logic [7:0]  ext_q, ext_d, evt_q, evt_d;
  logic [2:0]  sel_q, sel_d;
  logic        wr_q, wr_d;
  logic [7:0]  wa_q, wa_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] chan_q;
  logic [7:0]  gen0_q;
  logic [7:0]  pce_q, pve_q, pde_q, pdw_q, pdn_q;
  logic [15:0] ven_q, dev_q, evc_q;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    if (a == OFS_GEN)
      r = {16'h0, 4'h0, pdn_q != 0, pdw_q != 0, pde_q != 0,
           pve_q != 0, gen0_q};
    else if (a == OFS_CHAN)
      r = {16'h0, chan_q};
    else if (a == OFS_PORT_LO)
      r = {pde_q, pve_q, 8'h00, pce_q};
    else if (a == OFS_PORT_HI)
      r = {16'h0, pdn_q, pdw_q};
    else if (a == OFS_CFG)
      r = {24'h0, surv_q};
    else if (a == OFS_EXT_EN)
      r = {16'h0, evt_q, ext_q};
    else if (a == OFS_SEL)
      r = {29'h0, sel_q};
    else if (a == OFS_IDENT)
      r = {ven_q, dev_q};
    else if (a == OFS_EVENT)
      r = {16'h0, evc_q};
    return r;
  endfunction : rd_mux

  always_comb begin
    surv_d = surv_q;
    ext_d  = ext_q;
    evt_d  = evt_q;
    sel_d  = sel_q;
    rd_d   = rd_q;
    wr_d   = 1'b0;
    wa_d   = wa_q;
    if (wr_q) begin
      if (wa_q == OFS_CFG)
        surv_d = hwdata[7:0];
      else if (wa_q == OFS_EXT_EN) begin
        ext_d = hwdata[7:0];
        evt_d = hwdata[15:8];
      end else if (wa_q == OFS_SEL)
        sel_d = hwdata[2:0];
    end
    if (hsel && hready && htrans[1]) begin
      wr_d = hwrite;
      wa_d = haddr[7:0];
      if (!hwrite)
        rd_d = rd_mux(haddr[7:0]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      surv_q <= SURV_RST;
      ext_q  <= '0;
      evt_q  <= '0;
      sel_q  <= '0;
      wr_q   <= 1'b0;
      wa_q   <= '0;
      rd_q   <= '0;
    end else if (ce_i) begin
      surv_q <= surv_d;
      ext_q  <= ext_d;
      evt_q  <= evt_d;
      sel_q  <= sel_d;
      wr_q   <= wr_d;
      wa_q   <= wa_d;
      rd_q   <= rd_d;
    end
  end

  // ****************************************************
  // output channel surveillance
  // ****************************************************
  // counter wide enough for the longest window
  localparam int unsigned SCW = $clog2(SURV_MAX_MS * MSCYC + 1);
  logic [15:0]    cmd_q, cmd_d;
  logic [15:0]    chan_d, rise;
  logic [SCW-1:0] surv_cnt_q [NCH], surv_cnt_d [NCH];
  logic [15:0] filt_cnt_q [NCH], filt_cnt_d [NCH];

  always_comb begin
    cmd_d  = out_cmd_i;
    chan_d = chan_q;
    rise   = out_cmd_i & ~cmd_q;
    for (int i = 0; i < NCH; i++) begin
      surv_cnt_d[i] = surv_cnt_q[i];
      filt_cnt_d[i] = filt_cnt_q[i];
      if (rise[i])
        surv_cnt_d[i] = SCW'(surv_q * MSCYC);
      else if (surv_cnt_q[i] != 0)
        surv_cnt_d[i] = surv_cnt_q[i] - SCW'(1);
      if (out_cmd_i[i] != meas_s[i] && !rise[i]
          && surv_cnt_q[i] == 0) begin
        if (filt_cnt_q[i] != 16'(FILT))
          filt_cnt_d[i] = filt_cnt_q[i] + 16'd1;
      end else
        filt_cnt_d[i] = '0;
      chan_d[i] = (filt_cnt_q[i] == 16'(FILT));
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_q  <= '0;
      chan_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        surv_cnt_q[i] <= '0;
        filt_cnt_q[i] <= '0;
      end
    end else if (ce_i) begin
      cmd_q  <= cmd_d;
      chan_q <= chan_d;
      for (int i = 0; i < NCH; i++) begin
        surv_cnt_q[i] <= surv_cnt_d[i];
        filt_cnt_q[i] <= filt_cnt_d[i];
      end
    end
  end

  // ****************************************************
  // general and port diagnostics
  // ****************************************************
  logic [7:0]  gen0_d, pce_d, pve_d, pde_d, pdw_d, pdn_d;
  logic [15:0] ven_d, dev_d, evc_d;

  always_comb begin
    gen0_d = gen_s;
    gen0_d[B_ACT_SHRT] = gen_s[B_ACT_SHRT] | (|chan_q);
    pce_d = comm_s;
    pve_d = vmis_s;
    for (int p = 0; p < NPORT; p++) begin
      pde_d[p] = diag_class_t'(cls_s[2*p +: 2]) == DIAG_ERR;
      pdw_d[p] = diag_class_t'(cls_s[2*p +: 2]) == DIAG_WARN;
      pdn_d[p] = diag_class_t'(cls_s[2*p +: 2]) == DIAG_NOTE;
    end
    ven_d = ext_q[sel_q] ? sel_vendor_id_i : 16'h0000;
    dev_d = ext_q[sel_q] ? sel_device_id_i : 16'h0000;
    evc_d = evt_q[sel_q] ? sel_event_code_i : 16'h0000;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gen0_q <= '0;
      pce_q  <= '0;
      pve_q  <= '0;
      pde_q  <= '0;
      pdw_q  <= '0;
      pdn_q  <= '0;
      ven_q  <= '0;
      dev_q  <= '0;
      evc_q  <= '0;
    end else if (ce_i) begin
      gen0_q <= gen0_d;
      pce_q  <= pce_d;
      pve_q  <= pve_d;
      pde_q  <= pde_d;
      pdw_q  <= pdw_d;
      pdn_q  <= pdn_d;
      ven_q  <= ven_d;
      dev_q  <= dev_d;
      evc_q  <= evc_d;
    end
  end

  assign hrdata     = rd_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign port_sel_o = sel_q;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_short_flag: assert property (
    ce_i && (|chan_q) |=> gen0_q[B_ACT_SHRT])
    else $error("short flag missing");
  chk_gen_layout: assert property (
    ce_i |=> gen0_q[B_INT_ERR] == $past(gen_s[B_INT_ERR]))
    else $error("general byte layout wrong");
  chk_chan_mask: assert property (
    ce_i && surv_cnt_q[0] != 0 |=> filt_cnt_q[0] == 0 || !ce_i)
    else $error("error not masked");
  chk_surv_load: assert property (
    ce_i && out_cmd_i[0] && !cmd_q[0]
      |=> surv_cnt_q[0] == SCW'($past(surv_q) * MSCYC))
    else $error("surveillance load wrong");
  chk_filt_clear: assert property (
    ce_i && out_cmd_i[0] == meas_s[0] |=> filt_cnt_q[0] == 0)
    else $error("filter not cleared");
  chk_comm_bit: assert property (
    ce_i |=> pce_q == $past(comm_s))
    else $error("comm bit wrong");
  chk_valid_bit: assert property (
    ce_i |=> pve_q == $past(vmis_s))
    else $error("validation bit wrong");
  chk_class_excl: assert property (
    (pde_q & pdw_q) == 0 && (pdw_q & pdn_q) == 0)
    else $error("class bits overlap");
  chk_ident_gate: assert property (
    ce_i && !ext_q[sel_q] |=> ven_q == 0)
    else $error("identity not gated");
  chk_dev_gate: assert property (
    ce_i && !ext_q[sel_q] |=> dev_q == 0)
    else $error("device id not gated");
  chk_event_gate: assert property (
    ce_i && !evt_q[sel_q] |=> evc_q == 0)
    else $error("event not gated");
  chk_chan_report: assert property (
    ce_i && filt_cnt_q[1] == 16'(FILT) |=> chan_q[1] || !ce_i)
    else $error("channel bit missing");

  cov_rise: cover property (ce_i && out_cmd_i[0] && !cmd_q[0]);
  cov_chan: cover property (chan_q[0]);
  cov_comm: cover property (pce_q != 0);
  cov_evt:  cover property (evc_q != 0);
  cov_frz:  cover property (!ce_i ##1 ce_i);

endmodule : diag_image

// >>> src/diag_image_pkg.sv
// constants, offsets and types for the diagnostic image block
// assumes a 10 MHz clock and an ahb-lite master with single word transfers
package diag_image_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned SURV_DEFAULT_MS = 80;
  localparam int unsigned SURV_MAX_MS     = 255;
  localparam int unsigned FILT_MS         = 5;
  localparam int unsigned FILT_CYC        = FILT_MS * CYC_PER_MS;

  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [7:0] OFS_GEN     = 8'h00;
  localparam logic [7:0] OFS_CHAN    = 8'h04;
  localparam logic [7:0] OFS_PORT_LO = 8'h08;
  localparam logic [7:0] OFS_PORT_HI = 8'h0c;
  localparam logic [7:0] OFS_CFG     = 8'h10;
  localparam logic [7:0] OFS_EXT_EN  = 8'h14;
  localparam logic [7:0] OFS_SEL     = 8'h18;
  localparam logic [7:0] OFS_IDENT   = 8'h1c;
  localparam logic [7:0] OFS_EVENT   = 8'h20;

  // ****************************************************
  // general byte 0 bit positions
  // ****************************************************
  localparam int unsigned B_SYS_LOW   = 0;
  localparam int unsigned B_ACT_LOW   = 1;
  localparam int unsigned B_SENS_SHRT = 2;
  localparam int unsigned B_ACT_SHRT  = 3;
  localparam int unsigned B_UNDER_T   = 4;
  localparam int unsigned B_OVER_T    = 5;
  localparam int unsigned B_FORCED    = 6;
  localparam int unsigned B_INT_ERR   = 7;

  localparam logic [7:0] SURV_RST = 8'h50;

  typedef enum logic [1:0] {
    DIAG_NONE = 2'h0,
    DIAG_NOTE = 2'h1,
    DIAG_WARN = 2'h3,
    DIAG_ERR  = 2'h2
  } diag_class_t;

endpackage : diag_image_pkg

// >>> tb/diag_image_tb_top.sv
// self-checking bench for the diagnostic image block
// assumes the image_reader model and shortened filter counts
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module diag_image_tb_top;
  import diag_image_pkg::*;
  logic        mclk_i, rst_i, hsel, hwrite, hreadyout, hresp, ce;
  logic [15:0] cmd, meas, dclass, ven, dev, evt;
  logic [7:0]  gen, comm, vmis;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [2:0]  hsize, port_sel;
  int          fail_count, tests_run;

  diag_image #(.FILT(20), .MSCYC(4)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .out_cmd_i(cmd),
    .out_meas_i(meas), .gen_cond_i(gen), .port_comm_fault_i(comm),
    .port_valid_mismatch_i(vmis), .port_diag_class_i(dclass),
    .sel_vendor_id_i(ven), .sel_device_id_i(dev),
    .sel_event_code_i(evt), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .port_sel_o(port_sel));
  image_reader i_host (
    .mclk_i(mclk_i), .hready_i(hreadyout), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rdat);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    rd(OFS_CFG);
    `CHK(rdat[7:0], SURV_RST)
    wr(OFS_GEN, 32'hff);
    rd(OFS_GEN);
    `CHK(rdat, 32'h0)
    rd(8'h40);
    `CHK(rdat, 32'h0)
    $display("reset test done");
  endtask : t_reset
  task automatic t_gen;
    logic [7:0] pat [3];
    pat = '{8'ha5, 8'h5a, 8'h00};
    foreach (pat[i]) begin
      gen <= pat[i];
      cyc(6);
      rd(OFS_GEN);
      `CHK(rdat[7:0], pat[i])
    end
    $display("general byte test done");
  endtask : t_gen
  task automatic t_chan;
    wr(OFS_CFG, 32'ha);
    cmd <= 16'h8013;
    cyc(26);
    rd(OFS_CHAN);
    `CHK(rdat[15:0], 16'h0)
    cyc(60);
    rd(OFS_CHAN);
    `CHK(rdat[15:0], 16'h8013)
    rd(OFS_GEN);
    `CHK(rdat[3], 1'b1)
    meas <= 16'h8013;
    cyc(40);
    rd(OFS_CHAN);
    `CHK(rdat[15:0], 16'h0)
    meas <= 16'h8000;
    cyc(8);
    rd(OFS_CHAN);
    `CHK(rdat[15:0], 16'h0)
    cyc(40);
    rd(OFS_CHAN);
    `CHK(rdat[15:0], 16'h0013)
    cmd  <= 16'h0;
    meas <= 16'h0;
    $display("channel test done");
  endtask : t_chan
  task automatic t_port;
    comm   <= 8'h81;
    vmis   <= 8'h42;
    dclass <= 16'h001e;
    cyc(6);
    rd(OFS_PORT_LO);
    `CHK(rdat, 32'h01420081)
    rd(OFS_PORT_HI);
    `CHK(rdat[15:0], 16'h0402)
    rd(OFS_GEN);
    `CHK(rdat[11:8], 4'hf)
    comm   <= 8'h0;
    vmis   <= 8'h0;
    dclass <= 16'h0;
    cyc(6);
    rd(OFS_PORT_LO);
    `CHK(rdat, 32'h0)
    $display("port test done");
  endtask : t_port
  task automatic t_ext;
    ven <= 16'h1234;
    dev <= 16'h5678;
    evt <= 16'h9abc;
    wr(OFS_EXT_EN, 32'h0808);
    wr(OFS_SEL, 32'h3);
    cyc(2);
    `CHK(port_sel, 3'h3)
    rd(OFS_IDENT);
    `CHK(rdat, 32'h12345678)
    rd(OFS_EVENT);
    `CHK(rdat[15:0], 16'h9abc)
    wr(OFS_SEL, 32'h2);
    rd(OFS_IDENT);
    `CHK(rdat, 32'h0)
    rd(OFS_EVENT);
    `CHK(rdat[15:0], 16'h0)
    $display("identity test done");
  endtask : t_ext
  task automatic t_freeze;
    ce  <= 1'b0;
    gen <= 8'h81;
    cyc(6);
    ce  <= 1'b1;
    rd(OFS_GEN);
    `CHK(rdat[7:0], 8'h00)
    cyc(6);
    rd(OFS_GEN);
    `CHK(rdat[7:0], 8'h81)
    gen <= 8'h00;
    $display("freeze test done");
  endtask : t_freeze

  // ****************************************************
  // clock, sequence, watchdog
  // ****************************************************
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    {rst_i, cmd, meas, gen, comm, vmis} = {1'b1, 56'h0};
    {dclass, ven, dev, evt} = 64'h0;
    ce = 1'b1;
    fail_count = 0;
    tests_run = 0;
    cyc(6);
    rst_i <= 1'b0;
    t_reset();
    t_gen();
    t_chan();
    t_port();
    t_ext();
    t_freeze();
    tally_and_finish();
  end
  initial begin
    cyc(3000);
    fail_count++;
    tally_and_finish();
  end
endmodule : diag_image_tb_top

// >>> tb/image_reader.sv
// ahb-lite master standing in for the controller reading the image
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ns
module image_reader (
  input  wire logic        mclk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end

  // ****************************************************
  // single word transfer
  // ****************************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h0, a};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
    // released data lines show a changed value
    hwdata_o <= ~wd;
  endtask : xfer
endmodule : image_reader
